// file: hw/gper_top.sv
`timescale 1ns/1ns
// Behaviour
// - an enabled port's notifications stop going over the link and assert the event output.
// - each port enable is software read/write, resets to zero and is kept as a sticky bit.
// - the event output is driven as the alternate function of general purpose pin 15.
// - one read-only status bit per port reads one while that port signals, reset zero.
// - a port's status bit is set only if its enable bit was set in the cycle before.
// - the event pin is driven only while it is configured for its alternate function.
// - the polarity bit selects the output level: 0 active low, 1 active high.
module gper_top
   import gper_pkg::*;
#(
   parameter int NUM_PORTS = gper_pkg::GPER_NUM_PORTS
) (
   input  wire logic                      pclk,            // core clock
   input  wire logic                      presetn,         // async reset, active low
   input  wire logic                      sticky_rstn,     // fundamental reset, active low
   input  wire logic                      psel,            // apb select
   input  wire logic                      penable,         // apb enable
   input  wire logic                      pwrite,          // apb direction
   input  wire logic [gper_pkg::GPER_AW-1:0] paddr,        // apb byte address
   input  wire logic [31:0]               pwdata,          // apb write data
   input  wire logic [3:0]                pstrb,           // apb byte strobes
   output logic                           pready,          // apb ready
   output logic [31:0]                    prdata,          // apb read data
   output logic                           pslverr,         // apb error
   input  wire logic [NUM_PORTS-1:0]      port_notify_req, // per-port pending notification
   output logic [NUM_PORTS-1:0]           port_link_notify,// notification allowed on link
   output logic                           event_output_pin_signal_o,  // pin out level
   output logic                           event_output_pin_signal_oe, // pin output enable
   output logic                           irq              // level interrupt
);
   import gper_pkg::*;

   initial begin
      if (NUM_PORTS != GPER_NUM_PORTS) begin
         $error("gper_top serves exactly sixteen port bits");
      end
   end

   gper_state_t cur_ff;
   gper_state_t nxt_state;
   gper_state_t sticky_ff;

   logic        setup;
   logic        wr;
   logic [15:0] enables;
   logic [15:0] signalling;
   logic        any_event;
   logic [15:0] wmask;

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   // zero wait states: read data and error are registered in the setup cycle
   // so they already stand in the access cycle, when the master samples them
   assign pready  = 1'b1;
   assign setup   = psel && !penable;
   assign wr      = psel && penable && pwrite;
   assign wmask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // ------------------------------------------------------------------
   // routing
   // ------------------------------------------------------------------
   assign enables    = sticky_ff.control & GPER_PORT_MASK;
   assign signalling = enables & port_notify_req;
   assign any_event  = |signalling;
   // enabled ports are withheld from the link whatever their request state
   assign port_link_notify = port_notify_req & ~enables;

   always_comb begin
      nxt_state = cur_ff;
      // enables live in the sticky domain; fold them in, and cur_ff.control keeps a second, unused copy
      nxt_state.control = sticky_ff.control;
      nxt_state.status  = signalling;
      nxt_state.pslverr = 1'b0;
      nxt_state.prdata  = GPER_RDATA_ZERO;

      if (wr) begin
         unique case (paddr)
            GPER_OFS_CONTROL: begin
               nxt_state.control = (sticky_ff.control & ~wmask) | (pwdata[15:0] & wmask);
            end
            GPER_OFS_ALTFN: begin
               if (pstrb[0]) begin
                  nxt_state.altfn = pwdata[0];
               end
            end
            GPER_OFS_IRQ_MASK: begin
               nxt_state.irq_mask = (cur_ff.irq_mask & ~wmask) | (pwdata[15:0] & wmask);
            end
            GPER_OFS_IRQ_STS: begin
               nxt_state.irq_sts = cur_ff.irq_sts & ~(pwdata[15:0] & wmask);
            end
            GPER_OFS_STATUS: begin
            end
            default: begin
            end
         endcase
      end
      if (setup) begin
         unique case (paddr)
            GPER_OFS_CONTROL:  nxt_state.prdata = {16'h0000, sticky_ff.control};
            GPER_OFS_STATUS:   nxt_state.prdata = {16'h0000, cur_ff.status};
            GPER_OFS_ALTFN:    nxt_state.prdata = {31'h0000_0000, cur_ff.altfn};
            GPER_OFS_IRQ_STS:  nxt_state.prdata = {16'h0000, cur_ff.irq_sts};
            GPER_OFS_IRQ_MASK: nxt_state.prdata = {16'h0000, cur_ff.irq_mask};
            default:           nxt_state.pslverr = 1'b1;
         endcase
         if (pwrite) begin
            nxt_state.prdata = GPER_RDATA_ZERO;
         end
      end

      // a new signalling edge wins over a write-one clear in the same cycle
      nxt_state.irq_sts = nxt_state.irq_sts | (signalling & ~cur_ff.status);

      // active level from the polarity bit; idle is the opposite level
      nxt_state.pin_o  = sticky_ff.control[GPER_POL_BIT] ? any_event : ~any_event;
      nxt_state.pin_oe = nxt_state.altfn;
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // the enables survive presetn and clear only on the fundamental reset
   always_ff @(posedge pclk or negedge sticky_rstn) begin
      if (!sticky_rstn) begin
         sticky_ff         <= '0;
         sticky_ff.control <= GPER_CONTROL_RST;
      end else begin
         sticky_ff         <= '0;
         sticky_ff.control <= nxt_state.control;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_ff          <= '0;
         cur_ff.status   <= GPER_STATUS_RST;
         cur_ff.altfn    <= GPER_ALTFN_RST;
         cur_ff.irq_sts  <= GPER_IRQ_RST;
         cur_ff.irq_mask <= GPER_IRQ_RST;
         cur_ff.pin_o    <= 1'b1;
         cur_ff.pin_oe   <= 1'b0;
      end else begin
         cur_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign prdata  = cur_ff.prdata;
   assign pslverr = cur_ff.pslverr;
   // pin 15 carries the event as its alternate function
   assign event_output_pin_signal_o  = cur_ff.pin_o;
   assign event_output_pin_signal_oe = cur_ff.pin_oe;
   assign irq = |(cur_ff.irq_sts & cur_ff.irq_mask);
endmodule

// file: hw/gper_pkg.sv
package gper_pkg;
   // ------------------------------------------------------------------
   // widths and register map
   // ------------------------------------------------------------------
   localparam int          GPER_NUM_PORTS    = 16;
   localparam int          GPER_AW           = 12;
   localparam logic [11:0] GPER_OFS_CONTROL  = 12'h450;
   localparam logic [11:0] GPER_OFS_STATUS   = 12'h454;
   localparam logic [11:0] GPER_OFS_ALTFN    = 12'h458;
   localparam logic [11:0] GPER_OFS_IRQ_STS  = 12'h45C;
   localparam logic [11:0] GPER_OFS_IRQ_MASK = 12'h460;

   // ------------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------------
   localparam int           GPER_POL_BIT      = 0;
   localparam int           GPER_FIRST_PORT   = 1;
   localparam int           GPER_LAST_PORT    = 15;
   localparam int           GPER_PIN_INDEX    = 15;
   localparam logic [15:0]  GPER_PORT_MASK    = 16'hFFFE;
   localparam logic [15:0]  GPER_CONTROL_RST  = 16'h0000;
   localparam logic [15:0]  GPER_STATUS_RST   = 16'h0000;
   localparam logic [15:0]  GPER_IRQ_RST      = 16'h0000;
   localparam logic         GPER_ALTFN_RST    = 1'b0;
   localparam logic [31:0]  GPER_RDATA_ZERO   = 32'h0000_0000;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] control;   // bit0 polarity, bits 15:1 port enables
      logic [15:0] status;
      logic        altfn;
      logic [15:0] irq_sts;
      logic [15:0] irq_mask;
      logic [31:0] prdata;
      logic        pslverr;
      logic        pin_o;
      logic        pin_oe;
   } gper_state_t;
endpackage

// file: testbench/gper_monitor.sv
`timescale 1ns/1ns
module gper_monitor
   import gper_pkg::*;
(
   input wire logic        pclk, presetn, sticky_rstn,           // clock and resets
   input wire logic        psel, penable, pwrite, pready, pslverr, // apb control
   input wire logic [11:0] paddr,                                  // apb address
   input wire logic [31:0] pwdata, prdata,                         // apb data
   input wire logic        event_output_pin_signal_o,              // pin level
   input wire logic        event_output_pin_signal_oe,             // pin enable
   input wire logic [15:0] port_notify_req, port_link_notify       // port notifications
);
   logic [15:0] en_ff;
   logic        alt_ff;
   wire         wr = psel && penable && pwrite;
   wire  [15:0] act = port_notify_req & en_ff & 16'hFFFE;
   // shadow control follows only the fundamental reset, as the design's does
   always_ff @(posedge pclk or negedge sticky_rstn)
      if (!sticky_rstn) en_ff <= 16'h0000;
      else if (wr && paddr == 12'h450) en_ff <= pwdata[15:0];
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) alt_ff <= 1'b0;
      else if (wr && paddr == 12'h458) alt_ff <= pwdata[0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_s; psel && !penable; endsequence
   sequence bad_s;
      acc_s ##0 !(paddr inside {12'h450, 12'h454, 12'h458, 12'h45C, 12'h460});
   endsequence
   sequence rd_s(a); acc_s ##0 (!pwrite && paddr == a); endsequence
   link_mask_a: assert property (port_link_notify == (port_notify_req & ~act))
      else $error("link notify mismatch");
   pin_level_a: assert property ($past(presetn) |-> event_output_pin_signal_o ==
      ($past(en_ff[0]) ^ ~|$past(act))) else $error("pin level mismatch");
   oe_alt_a: assert property (event_output_pin_signal_oe == alt_ff)
      else $error("pin enable mismatch");
   sts_en_a: assert property (rd_s(12'h454) |=> prdata == {16'h0000, $past(act, 2)})
      else $error("status mismatch");
   ctl_rd_a: assert property (rd_s(12'h450) |=> prdata == {16'h0000, $past(en_ff)})
      else $error("control readback mismatch");
   bad_addr_a: assert property (bad_s |=> pslverr) else $error("no error on unmapped address");
   rd_idle_a: assert property (!(psel && !penable) |=> prdata == 32'h0 && !pslverr)
      else $error("read data not cleared");
   ready_hi_a: assert property (pready) else $error("ready low");
endmodule
bind gper_top gper_monitor u_mon (.pclk, .presetn, .sticky_rstn, .psel, .penable, .pwrite,
   .pready, .pslverr, .paddr, .pwdata, .prdata, .event_output_pin_signal_o,
   .event_output_pin_signal_oe, .port_notify_req, .port_link_notify);

// file: testbench/gper_board.sv
`timescale 1ns/1ns
module gper_board (
   input wire logic o,   // driven level
   input wire logic oe,  // driver enable
   input wire logic pol, // active level
   output logic     seen // board sees an event
);
   // a released pin floats to the board pull-up
   wire lvl = oe ? o : 1'b1;
   assign seen = (lvl == pol);
endmodule

// file: testbench/tb_general_purpose_event_routing.sv
`timescale 1ns/1ns
module tb_general_purpose_event_routing;
   import gper_pkg::*;
   logic        pclk, presetn, sticky_rstn, psel, penable, pwrite, pready, pslverr, irq;
   logic        pin_o, pin_oe, pol, seen, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] req, link, en;
   logic [3:0]  pstrb;
   int          error_cnt, checked;
   gper_top dut (.pclk, .presetn, .sticky_rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .pready, .prdata, .pslverr, .port_notify_req(req), .port_link_notify(link),
      .event_output_pin_signal_o(pin_o), .event_output_pin_signal_oe(pin_oe), .irq);
   gper_board board (.o(pin_o), .oe(pin_oe), .pol, .seen);
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   function automatic logic [15:0] act(input logic [15:0] r, e);
      return r & e & GPER_PORT_MASK;
   endfunction
   task automatic conclude(input int to);
      error_cnt += to;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // entered just after a rising edge; request held until pready is seen high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk) n++; while (pready !== 1'b1 && n < 20);
      {q, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge pclk);
      if (n >= 20) conclude(1);
   endtask
   initial begin
      {presetn, sticky_rstn, psel, penable, pwrite, paddr, pwdata, req, pol} = '0;
      {error_cnt, checked} = '0;
      pstrb = 4'hF;
      void'($urandom(29472));
      repeat (4) @(posedge pclk);
      {presetn, sticky_rstn} <= 2'b11;
      @(posedge pclk);
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, 12'h450 + 12'(4 * i), 32'h0);
         chk(q, 32'h0);
      end
      xfer(1'b0, 12'h464, 32'h0);
      chk(err, 1'b1);
      for (int i = 0; i < 40; i++) begin
         en = (i < 2) ? 16'hFFFF : 16'($urandom);
         pol = en[0];
         xfer(1'b1, 12'h450, {16'($urandom), en});
         xfer(1'b1, 12'h458, 32'h1);
         req <= (i < 2) ? {16{i[0]}} : 16'($urandom);
         repeat (2) @(posedge pclk);
         chk(link, req & ~act(req, en));
         chk(seen, |act(req, en));
         xfer(1'b0, 12'h454, 32'h0);
         chk(q, act(req, en));
         xfer(1'b0, 12'h450, 32'h0);
         chk(q, en);
      end
      xfer(1'b1, 12'h458, 32'h0);
      chk(pin_oe, 1'b0);
      req <= 16'h0000;
      xfer(1'b1, 12'h450, 32'h8001);
      xfer(1'b1, 12'h45C, 32'hFFFF);
      for (int m = 0; m < 2; m++) begin
         xfer(1'b1, 12'h460, m ? 32'h0 : 32'hFFFF);
         req <= 16'h8000;
         repeat (2) @(posedge pclk);
         chk(irq, m == 0);
         req <= 16'h0000;
         xfer(1'b0, 12'h45C, 32'h0);
         chk(q, 32'h8000);
         xfer(1'b1, 12'h45C, 32'h8000);
         xfer(1'b0, 12'h45C, 32'h0);
         chk(q | irq, 32'h0);
      end
      presetn <= 1'b0;
      @(posedge pclk) presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, 12'h450, 32'h0);
      chk(q, 32'h8001);
      conclude(0);
   end
endmodule
